// [common/pis_pkg.sv]
package pis_pkg;
   // status / interrupt / index bit
   localparam int SB_TFL = 6;
   localparam logic [2:0] IRQ_LVL = 3'h5;
   localparam int IDX_BIT = 5;
   // psr flag positions
   localparam int PSR_EQ = 0;
   localparam int PSR_LO = 1;
   localparam int PSR_HI = 2;
   localparam int PSR_CY = 3;
   // opcodes, bit 5 set selects indexed form
   localparam logic [7:0] OP_MVC = 8'h00, OP_ZAZ = 8'h01, OP_ALC = 8'h02, OP_SLC = 8'h03;
   localparam logic [7:0] OP_AZ = 8'h04, OP_SZ = 8'h05, OP_ITC = 8'h06, OP_MVX = 8'h07;
   localparam logic [7:0] OP_ED = 8'h08, OP_CLC = 8'h09;
   localparam logic [7:0] OP_L = 8'h40, OP_A = 8'h41, OP_S = 8'h42, OP_TBN = 8'h43;
   localparam logic [7:0] OP_TBF = 8'h44, OP_CLI = 8'h45, OP_SRC = 8'h46, OP_SLI = 8'h47;
   localparam logic [7:0] OP_SBN = 8'h48, OP_SBF = 8'h49, OP_MVI = 8'h4a;
   localparam logic [7:0] OP_BR = 8'hc0, OP_LA = 8'hc1, OP_LPMR = 8'hc2, OP_SVC = 8'hc3;
   // instruction lengths in bytes
   localparam logic [2:0] LEN_TWO = 3'h6, LEN_ONE = 3'h4, LEN_CTL = 3'h5;
   // task save / load last byte index (four saved, three loaded)
   localparam logic [1:0] SAVE_LAST = 2'h3, LOAD_LAST = 2'h2;
   typedef enum logic [9:0] {
      S_ALT = 10'h001, S_FST = 10'h002, S_IF = 10'h004, S_DEC = 10'h008, S_RD2 = 10'h010,
      S_RD1 = 10'h020, S_EXE = 10'h040, S_WR = 10'h080, S_SAVE = 10'h100, S_LOAD = 10'h200
   } pis_st_t;
   typedef enum logic [6:0] {
      M_IDLE = 7'h01, M_ROW = 7'h02, M_COL = 7'h04, M_SEL = 7'h08,
      M_DATA = 7'h10, M_HOLD = 7'h20, M_REL = 7'h40
   } pis_mst_t;
endpackage : pis_pkg

// [logic/pis_sequencer.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - write cycle: row address and strobe, then column and strobe, then write select.
// - after address latch, write data is driven and latched into storage.
// - address and select drop only after the write data was latched.
// - an instruction fetch starts only while run permit is active and instructions remain.
// - fetch start leaves alternate mode; status byte bit 6 starts a task load.
// - instruction address is translated to a real address for the fetch read.
// - instruction address steps for each byte, ending past the instruction.
// - two-address forms load indexed operand addresses into both operand registers.
// - move and zero-add read operand two only, write result to operand one.
// - arithmetic, insert, move-hex, edit read operand two then one, write one.
// - length byte counts operand bytes; move-hex ignores it; shift-right uses it.
// - compare-characters reads both operands, sets status, writes nothing.
// - one-address forms load indexed address; most read operand one.
// - only subtract, set-bits, move-immediate, shift-right write operand one back.
// - one-address forms may update status and the local register stack.
// - control forms other than supervisor call finish in decode right after the fetch, with no operand access.
// - branch on status-mask match saves address to recall, loads target.
// - load-address and load-mode take their value from the instruction.
// - supervisor call or bad opcode stores third byte in recall slot, then saves.
// - supervisor call or bad opcode raises a level 5 interrupt request.
// - alternate mode holds until run permit, then a new fetch starts.
// - read: gate after address latch; storage data held until release.
// - task save writes from the area's end toward lower addresses.
module pis_sequencer import pis_pkg::*; (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // control service processor side
   input wire logic i_run_permit_n,
   input wire logic i_more_instr,
   input wire logic [7:0] i_status_byte2,
   input wire logic [15:0] i_xlate_base,
   input wire logic [15:0] i_index_value,
   input wire logic [15:0] i_save_end,
   input wire logic [15:0] i_load_end,
   output logic o_alt_mode,
   output logic o_irq5_req,
   output logic [2:0] o_irq_level,
   // program state
   output logic [15:0] o_iar,
   output logic [15:0] o_arr,
   output logic [7:0] o_psr,
   output logic [7:0] o_pmr,
   output logic [7:0] o_recall_slot,
   output logic [7:0] o_lsr_acc,
   output logic [15:0] o_lsr_xr,
   // main storage
   output logic [7:0] o_ms_addr,
   output logic o_ras_n,
   output logic o_cas_n,
   output logic o_rw_sel,
   output logic o_dout_gate_n,
   output logic [7:0] o_ms_wdata,
   output logic o_ms_wdata_oe_n,
   input wire logic [7:0] i_ms_rdata
);
   function automatic logic [15:0] real_a(input logic [15:0] a, input logic [15:0] b);
      return a + b;
   endfunction : real_a
   function automatic logic is_two(input logic [7:0] b);
      return b[7:6] == 2'b00 && b <= OP_CLC;
   endfunction : is_two
   function automatic logic is_one(input logic [7:0] b);
      return b[7:6] == 2'b01 && b <= OP_MVI;
   endfunction : is_one
   function automatic logic [2:0] ilen(input logic [7:0] o);
      logic [7:0] b;
      b = o & ~8'h20;
      return is_two(b) ? LEN_TWO : (is_one(b) ? LEN_ONE : LEN_CTL);
   endfunction : ilen
   function automatic logic [2:0] cmp(input logic [7:0] a, input logic [7:0] b);
      return {a > b, a < b, a == b};
   endfunction : cmp
   // {carry, result}; subtract, set-bits and move-immediate take the immediate from q
   function automatic logic [8:0] alu(input logic [7:0] op, input logic [7:0] a,
         input logic [7:0] b, input logic [7:0] q, input logic c);
      case (op)
         OP_ALC, OP_AZ, OP_A: return {1'b0, a} + {1'b0, b} + {8'h00, c};
         OP_SLC, OP_SZ: return {1'b0, a} - {1'b0, b} - {8'h00, c};
         OP_S: return {1'b0, a} - {1'b0, q};
         OP_MVX: return {1'b0, a[7:4], b[3:0]};
         OP_MVC, OP_ZAZ, OP_ITC, OP_ED: return {1'b0, b};
         OP_SBN: return {1'b0, a | q};
         OP_SBF: return {1'b0, a & ~q};
         OP_MVI: return {1'b0, q};
         OP_SRC: return {a[0], c, a[7:1]};
         default: return {1'b0, a};
      endcase
   endfunction : alu

   pis_st_t st_r, st_nxt;
   pis_mst_t m_r, m_nxt;
   logic [15:0] iar_r, iar_nxt, arr_r, arr_nxt, op1_r, op1_nxt, op2_r, op2_nxt;
   logic [15:0] xr_r, xr_nxt, maddr_r, maddr_nxt;
   logic [7:0] psr_r, psr_nxt, pmr_r, pmr_nxt, rcl_r, rcl_nxt, acc_r, acc_nxt;
   logic [7:0] cnt_r, cnt_nxt, o2v_r, o2v_nxt, o1v_r, o1v_nxt, rdat_r, rdat_nxt;
   logic [7:0] mwd_r, mwd_nxt;
   logic [7:0] ib_r [6];
   logic [7:0] ib_nxt [6];
   logic [2:0] bidx_r, bidx_nxt;
   logic [1:0] sidx_r, sidx_nxt;
   logic mwr_r, mwr_nxt, cy_r, cy_nxt, irq_r, irq_nxt;
   logic mdone, mreq, rq_w, adv;
   logic [15:0] rq_a, ixv;
   logic [7:0] rq_d, base, q, a2;
   logic [8:0] r;
   logic [2:0] f;

   assign mdone = m_r == M_REL;
   assign base = ib_r[0] & ~8'h20;
   assign q = ib_r[1];
   // strobes decode straight from the registered cycle state
   assign o_ras_n = !(m_r inside {M_ROW, M_COL, M_SEL, M_DATA, M_HOLD});
   assign o_cas_n = !(m_r inside {M_COL, M_SEL, M_DATA, M_HOLD});
   assign o_ms_addr = (m_r == M_ROW) ? maddr_r[15:8] : (o_cas_n ? 8'h00 : maddr_r[7:0]);
   assign o_rw_sel = mwr_r && (m_r inside {M_SEL, M_DATA, M_HOLD});
   assign o_ms_wdata_oe_n = !(mwr_r && (m_r inside {M_DATA, M_HOLD}));
   assign o_dout_gate_n = !(!mwr_r && (m_r inside {M_DATA, M_HOLD, M_REL}));
   assign o_ms_wdata = mwd_r;
   assign o_alt_mode = st_r == S_ALT;
   assign o_irq5_req = irq_r;
   assign o_irq_level = irq_r ? IRQ_LVL : 3'h0;
   assign o_iar = iar_r;
   assign o_arr = arr_r;
   assign o_psr = psr_r;
   assign o_pmr = pmr_r;
   assign o_recall_slot = rcl_r;
   assign o_lsr_acc = acc_r;
   assign o_lsr_xr = xr_r;

   always_comb begin
      st_nxt = st_r; m_nxt = m_r; iar_nxt = iar_r; arr_nxt = arr_r;
      op1_nxt = op1_r; op2_nxt = op2_r; xr_nxt = xr_r; maddr_nxt = maddr_r;
      psr_nxt = psr_r; pmr_nxt = pmr_r; rcl_nxt = rcl_r; acc_nxt = acc_r;
      cnt_nxt = cnt_r; o2v_nxt = o2v_r; o1v_nxt = o1v_r; rdat_nxt = rdat_r;
      mwd_nxt = mwd_r; ib_nxt = ib_r; bidx_nxt = bidx_r; sidx_nxt = sidx_r;
      mwr_nxt = mwr_r; cy_nxt = cy_r; irq_nxt = 1'b0;
      mreq = 1'b0; rq_w = 1'b0; rq_a = 16'h0000; rq_d = 8'h00; adv = 1'b0;
      ixv = ib_r[0][IDX_BIT] ? i_index_value : 16'h0000;
      a2 = is_two(base) ? o2v_r : acc_r;
      r = alu(base, o1v_r, a2, q, cy_r);
      f = 3'h0;
      // storage cycle: row, column, select, data/gate, latch, release
      case (m_r)
         M_ROW: m_nxt = M_COL;
         M_COL: m_nxt = M_SEL;
         M_SEL: m_nxt = M_DATA;
         M_DATA: m_nxt = M_HOLD;
         M_HOLD: m_nxt = M_REL;
         default: m_nxt = M_IDLE;
      endcase
      if (m_r == M_HOLD && !mwr_r) rdat_nxt = i_ms_rdata;
      case (st_r)
         S_ALT: if (!i_run_permit_n) st_nxt = S_FST;
         S_FST: begin
            if (i_run_permit_n) begin
               st_nxt = S_ALT;
            end else if (i_more_instr) begin
               mreq = 1'b1;
               if (i_status_byte2[SB_TFL]) begin
                  st_nxt = S_LOAD;
                  sidx_nxt = 2'h0;
                  rq_a = i_load_end;
               end else begin
                  st_nxt = S_IF;
                  bidx_nxt = 3'h0;
                  rq_a = real_a(iar_r, i_xlate_base);
               end
            end
         end
         S_IF: if (mdone) begin
            ib_nxt[bidx_r] = rdat_r;
            iar_nxt = iar_r + 16'h0001;
            if (3'(bidx_r + 3'h1) == ilen(bidx_r == 3'h0 ? rdat_r : ib_r[0])) begin
               st_nxt = S_DEC;
            end else begin
               bidx_nxt = 3'(bidx_r + 3'h1);
               mreq = 1'b1;
               rq_a = real_a(iar_nxt, i_xlate_base);
            end
         end
         S_DEC: begin
            cy_nxt = 1'b0;
            st_nxt = S_FST;
            if (is_two(base)) begin
               op1_nxt = {ib_r[2], ib_r[3]} + ixv;
               op2_nxt = {ib_r[4], ib_r[5]} + ixv;
               cnt_nxt = (base == OP_MVX) ? 8'h00 : q;
               mreq = 1'b1;
               rq_a = real_a(op2_nxt, i_xlate_base);
               st_nxt = S_RD2;
            end else if (is_one(base)) begin
               op1_nxt = {ib_r[2], ib_r[3]} + ixv;
               cnt_nxt = (base == OP_SRC) ? q : 8'h00;
               if (base == OP_MVI) begin
                  st_nxt = S_EXE;
               end else begin
                  mreq = 1'b1;
                  rq_a = real_a(op1_nxt, i_xlate_base);
                  st_nxt = S_RD1;
               end
            end else if (base == OP_BR) begin
               if (|(psr_r & q)) begin
                  arr_nxt = iar_r;
                  iar_nxt = {ib_r[3], ib_r[4]};
               end
               // mismatch falls through to the next sequential fetch
            end else if (base == OP_LA) begin
               xr_nxt = {ib_r[3], ib_r[4]};
            end else if (base == OP_LPMR) begin
               pmr_nxt = ib_r[2];
            end else begin
               rcl_nxt = ib_r[2];
               irq_nxt = 1'b1;
               sidx_nxt = 2'h0;
               mreq = 1'b1;
               rq_w = 1'b1;
               rq_a = i_save_end;
               rq_d = ib_r[2];
               st_nxt = S_SAVE;
            end
         end
         S_RD2: if (mdone) begin
            o2v_nxt = rdat_r;
            if (base == OP_MVC || base == OP_ZAZ) begin
               st_nxt = S_EXE;
            end else begin
               mreq = 1'b1;
               rq_a = real_a(op1_r, i_xlate_base);
               st_nxt = S_RD1;
            end
         end
         S_RD1: if (mdone) begin
            o1v_nxt = rdat_r;
            st_nxt = S_EXE;
         end
         S_EXE: begin
            cy_nxt = r[8];
            if (base == OP_CLC) f = cmp(o1v_r, o2v_r);
            else if (base == OP_CLI) f = cmp(o1v_r, q);
            else if (base == OP_TBN) f = {2'b00, (o1v_r & q) == q};
            else if (base == OP_TBF) f = {2'b00, (o1v_r & q) == 8'h00};
            else f = {2'b00, r[7:0] == 8'h00};
            if (!(base inside {OP_MVC, OP_ITC, OP_MVX, OP_MVI, OP_L, OP_SLI}))
               psr_nxt = {4'h0, r[8], f};
            if (base == OP_L || base == OP_A) acc_nxt = r[7:0];
            if ((is_two(base) && base != OP_CLC) ||
                  (base inside {OP_S, OP_SBN, OP_SBF, OP_MVI, OP_SRC})) begin
               mreq = 1'b1;
               rq_w = 1'b1;
               rq_a = real_a(op1_r, i_xlate_base);
               rq_d = r[7:0];
               st_nxt = S_WR;
            end else begin
               adv = 1'b1;
            end
         end
         S_WR: if (mdone) adv = 1'b1;
         S_SAVE: if (mdone) begin
            if (sidx_r == SAVE_LAST) begin
               st_nxt = S_ALT;
            end else begin
               sidx_nxt = 2'(sidx_r + 2'h1);
               mreq = 1'b1;
               rq_w = 1'b1;
               rq_a = i_save_end - {14'h0000, sidx_nxt};
               case (sidx_nxt)
                  2'h1: rq_d = psr_r;
                  2'h2: rq_d = iar_r[7:0];
                  default: rq_d = iar_r[15:8];
               endcase
            end
         end
         S_LOAD: if (mdone) begin
            case (sidx_r)
               2'h0: psr_nxt = rdat_r;
               2'h1: iar_nxt[7:0] = rdat_r;
               default: iar_nxt[15:8] = rdat_r;
            endcase
            mreq = 1'b1;
            if (sidx_r == LOAD_LAST) begin
               st_nxt = S_IF;
               bidx_nxt = 3'h0;
               rq_a = real_a(iar_nxt, i_xlate_base);
            end else begin
               sidx_nxt = 2'(sidx_r + 2'h1);
               rq_a = i_load_end - {14'h0000, sidx_nxt};
            end
         end
         default: st_nxt = S_ALT;
      endcase
      // next operand byte, rightmost first
      if (adv) begin
         if (cnt_r == 8'h00) begin
            st_nxt = S_FST;
         end else begin
            cnt_nxt = cnt_r - 8'h01;
            op1_nxt = op1_r - 16'h0001;
            op2_nxt = op2_r - 16'h0001;
            mreq = 1'b1;
            rq_a = real_a(is_two(base) ? op2_nxt : op1_nxt, i_xlate_base);
            st_nxt = is_two(base) ? S_RD2 : S_RD1;
         end
      end
      // a new cycle may overlap only the release of the previous one
      if (mreq) begin
         m_nxt = M_ROW;
         maddr_nxt = rq_a;
         mwr_nxt = rq_w;
         mwd_nxt = rq_d;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_r <= S_ALT; m_r <= M_IDLE; iar_r <= '0; arr_r <= '0; op1_r <= '0; op2_r <= '0;
         xr_r <= '0; maddr_r <= '0; psr_r <= '0; pmr_r <= '0; rcl_r <= '0; acc_r <= '0;
         cnt_r <= '0; o2v_r <= '0; o1v_r <= '0; rdat_r <= '0; mwd_r <= '0;
         ib_r <= '{default: 8'h00}; bidx_r <= '0; sidx_r <= '0;
         mwr_r <= 1'b0; cy_r <= 1'b0; irq_r <= 1'b0;
      end else begin
         st_r <= st_nxt; m_r <= m_nxt; iar_r <= iar_nxt; arr_r <= arr_nxt; op1_r <= op1_nxt;
         op2_r <= op2_nxt; xr_r <= xr_nxt; maddr_r <= maddr_nxt; psr_r <= psr_nxt;
         pmr_r <= pmr_nxt; rcl_r <= rcl_nxt; acc_r <= acc_nxt; cnt_r <= cnt_nxt;
         o2v_r <= o2v_nxt; o1v_r <= o1v_nxt; rdat_r <= rdat_nxt; mwd_r <= mwd_nxt;
         ib_r <= ib_nxt; bidx_r <= bidx_nxt; sidx_r <= sidx_nxt;
         mwr_r <= mwr_nxt; cy_r <= cy_nxt; irq_r <= irq_nxt;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   sequence s_row; !o_ras_n && o_cas_n && !o_rw_sel; endsequence
   sequence s_col; !o_cas_n && !o_rw_sel; endsequence
   a_write_order: assert property ($fell(o_ras_n) && mwr_r |-> s_row ##1 s_col ##1 o_rw_sel)
      else $error("write strobes out of order");
   a_data_after: assert property ($fell(o_ms_wdata_oe_n) |-> o_rw_sel && $past(o_rw_sel) && !o_cas_n)
      else $error("write data before address latch");
   a_write_release: assert property ($fell(o_rw_sel) |-> $past(!o_ms_wdata_oe_n, 1) && $past(!o_ms_wdata_oe_n, 2))
      else $error("write select dropped early");
   a_read_gate: assert property ($fell(o_dout_gate_n) |-> !o_cas_n && !o_rw_sel ##2 o_cas_n ##1 o_dout_gate_n)
      else $error("read gate timing wrong");
   a_run_gate: assert property (st_r == S_FST && (i_run_permit_n || !i_more_instr) |=> st_r != S_IF)
      else $error("fetch without permit");
   a_alt_hold: assert property (st_r == S_ALT && i_run_permit_n |=> st_r == S_ALT)
      else $error("left alternate mode without permit");
   a_task_load: assert property (st_r == S_FST && !i_run_permit_n && i_more_instr && i_status_byte2[SB_TFL]
      |=> st_r == S_LOAD ##1 !o_ras_n)
      else $error("task load not started");
   a_iar_step: assert property (st_r == S_IF && mdone |=> iar_r == $past(iar_r) + 16'h0001)
      else $error("instruction address not stepped");
   a_branch_take: assert property (st_r == S_DEC && base == OP_BR && |(psr_r & q)
      |=> arr_r == $past(iar_r) && iar_r == {$past(ib_r[3]), $past(ib_r[4])} && st_r == S_FST)
      else $error("branch not taken");
   a_branch_skip: assert property (st_r == S_DEC && base == OP_BR && !(|(psr_r & q))
      |=> iar_r == $past(iar_r) && arr_r == $past(arr_r))
      else $error("untaken branch changed address");
   a_svc_irq: assert property (st_r == S_DEC && base == OP_SVC
      |=> o_irq5_req && o_irq_level == IRQ_LVL && o_recall_slot == $past(ib_r[2]) && st_r == S_SAVE)
      else $error("supervisor call not serviced");
endmodule : pis_sequencer

// [verification/pis_storage_model.sv]
`timescale 1ns/10ps
module pis_storage_model (
   // storage pins from the sequencer
   input wire logic i_clk,
   input wire logic [7:0] i_ms_addr,
   input wire logic i_ras_n,
   input wire logic i_cas_n,
   input wire logic i_rw_sel,
   input wire logic i_dout_gate_n,
   input wire logic [7:0] i_ms_wdata,
   input wire logic i_ms_wdata_oe_n,
   // data back to the sequencer
   output logic [7:0] o_ms_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] row_r = 8'h00;
   logic [7:0] col_r = 8'h00;
   logic [7:0] last_r = 8'h00;
   logic ras_d = 1'b1;
   logic cas_d = 1'b1;
   logic wsel_r = 1'b0;

   always @(posedge i_clk) begin
      ras_d <= i_ras_n;
      cas_d <= i_cas_n;
      if (!i_ras_n && ras_d) row_r <= i_ms_addr;
      if (!i_cas_n && cas_d) col_r <= i_ms_addr;
      // select taken only while both strobes are down
      if (!i_ras_n && !i_cas_n) wsel_r <= i_rw_sel;
      if (!i_ras_n && !i_cas_n && wsel_r && !i_ms_wdata_oe_n) mem[{row_r, col_r}] <= i_ms_wdata;
      if (!i_dout_gate_n) last_r <= o_ms_rdata;
   end

   // released bus shows the inverse so a late sample cannot pass by luck
   always_comb o_ms_rdata = !i_dout_gate_n ? mem[{row_r, col_r}] : ~last_r;
endmodule : pis_storage_model

// [verification/testbench.sv]
`timescale 1ns/10ps
module testbench;
   import pis_pkg::*;
   typedef struct {
      logic [7:0] op;
      logic [7:0] q;
      logic [15:0] d1;
      logic [15:0] d2;
      logic [15:0] ex;
   } pis_row_t;
   localparam logic [15:0] BASE = 16'h0100;
   localparam logic [15:0] IDX = 16'h0010;
   localparam logic [15:0] SAVE_END = 16'h0e03;
   localparam logic [15:0] LOAD_END = 16'h0f02;
   // whole program needs about 700 cycles
   localparam int WD_CYCLES = 20000;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_run_permit_n = 1'b1;
   logic i_more_instr = 1'b0;
   logic [7:0] i_status_byte2 = 8'h00;
   logic [15:0] i_xlate_base = BASE;
   logic [15:0] i_index_value = IDX;
   logic [15:0] i_save_end = SAVE_END;
   logic [15:0] i_load_end = LOAD_END;
   logic o_alt_mode, o_irq5_req, o_ras_n, o_cas_n, o_rw_sel, o_dout_gate_n, o_ms_wdata_oe_n;
   logic [2:0] o_irq_level;
   logic [15:0] o_iar, o_arr, o_lsr_xr;
   logic [7:0] o_psr, o_pmr, o_recall_slot, o_lsr_acc, o_ms_addr, o_ms_wdata, i_ms_rdata;
   int error_cnt = 0;
   int n_checks = 0;
   // one instruction per row, operands in slot i; indexed row addresses are pre-biased
   pis_row_t rows [6] = '{
      '{OP_MVC, 8'h00, 16'h11aa, 16'h2255, 16'h1155},
      '{OP_MVC, 8'h01, 16'h11aa, 16'h2255, 16'h2255},
      '{OP_ALC, 8'h01, 16'h12f0, 16'h0120, 16'h1410},
      '{OP_SLC, 8'h00, 16'h11aa, 16'h2205, 16'h11a5},
      '{OP_MVC | 8'h20, 8'h00, 16'h3344, 16'h5566, 16'h3366},
      '{OP_CLC, 8'h01, 16'h11aa, 16'h2255, 16'h11aa}
   };

   always #12.5 i_clk = ~i_clk;

   pis_sequencer i_dut (
      .i_clk(i_clk), .i_srst(i_srst), .i_run_permit_n(i_run_permit_n), .i_more_instr(i_more_instr),
      .i_status_byte2(i_status_byte2), .i_xlate_base(i_xlate_base), .i_index_value(i_index_value),
      .i_save_end(i_save_end), .i_load_end(i_load_end), .o_alt_mode(o_alt_mode), .o_irq5_req(o_irq5_req),
      .o_irq_level(o_irq_level), .o_iar(o_iar), .o_arr(o_arr), .o_psr(o_psr), .o_pmr(o_pmr),
      .o_recall_slot(o_recall_slot), .o_lsr_acc(o_lsr_acc), .o_lsr_xr(o_lsr_xr), .o_ms_addr(o_ms_addr),
      .o_ras_n(o_ras_n), .o_cas_n(o_cas_n), .o_rw_sel(o_rw_sel), .o_dout_gate_n(o_dout_gate_n),
      .o_ms_wdata(o_ms_wdata), .o_ms_wdata_oe_n(o_ms_wdata_oe_n), .i_ms_rdata(i_ms_rdata));

   pis_storage_model i_mem (
      .i_clk(i_clk), .i_ms_addr(o_ms_addr), .i_ras_n(o_ras_n), .i_cas_n(o_cas_n), .i_rw_sel(o_rw_sel),
      .i_dout_gate_n(o_dout_gate_n), .i_ms_wdata(o_ms_wdata), .i_ms_wdata_oe_n(o_ms_wdata_oe_n),
      .o_ms_rdata(i_ms_rdata));

   task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
      n_checks++;
      if (got !== ex) begin
         $display("BAD %s expected %h seen %h", nm, ex, got);
         error_cnt++;
      end
   endtask : chk

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   // six bytes at a logical address; shorter forms get overwritten by the next one
   task automatic put_ins(input logic [15:0] la, input logic [7:0] op, input logic [7:0] q,
                          input logic [15:0] x, input logic [15:0] y);
      logic [15:0] ra;
      ra = la + BASE;
      i_mem.mem[ra] = op;
      i_mem.mem[ra + 16'h1] = q;
      i_mem.mem[ra + 16'h2] = x[15:8];
      i_mem.mem[ra + 16'h3] = x[7:0];
      i_mem.mem[ra + 16'h4] = y[15:8];
      i_mem.mem[ra + 16'h5] = y[7:0];
   endtask : put_ins

   function automatic logic [15:0] mw(input logic [15:0] a);
      return {i_mem.mem[a - 16'h1], i_mem.mem[a]};
   endfunction : mw

   task automatic hold_idle(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(negedge i_clk);
         if (o_ras_n !== 1'b1) seen = 1'b1;
      end
      chk("no storage cycle", 16'h0, 16'(seen));
   endtask : hold_idle

   task automatic wait_for(input logic want_irq, input int lim);
      int k;
      k = 0;
      @(negedge i_clk);
      while ((want_irq ? o_irq5_req : o_alt_mode) !== 1'b1 && k < lim) begin
         @(negedge i_clk);
         k++;
      end
      chk(want_irq ? "irq request" : "alternate mode", 16'h1, 16'(want_irq ? o_irq5_req : o_alt_mode));
      if (want_irq) chk("irq level", 16'(IRQ_LVL), 16'(o_irq_level));
   endtask : wait_for

   // write select may stand only under both strobes, data only under write select
   always @(negedge i_clk) begin
      if (!i_srst && o_rw_sel === 1'b1) chk("strobes under write", 16'h0, 16'({o_ras_n, o_cas_n}));
      if (!i_srst && o_ms_wdata_oe_n === 1'b0) chk("select under data", 16'h1, 16'(o_rw_sel));
   end

   initial begin
      repeat (WD_CYCLES) @(posedge i_clk);
      error_cnt++;
      complete_run();
   end

   initial begin
      logic [15:0] off;
      logic [15:0] bias;
      for (int i = 0; i < 6; i++) begin
         off = 16'(4 * i);
         bias = rows[i].op[IDX_BIT] ? IDX : 16'h0;
         put_ins(16'(6 * i), rows[i].op, rows[i].q, 16'h0201 + off - bias, 16'h0203 + off - bias);
         {i_mem.mem[16'h0300 + off], i_mem.mem[16'h0301 + off]} = rows[i].d1;
         {i_mem.mem[16'h0302 + off], i_mem.mem[16'h0303 + off]} = rows[i].d2;
      end
      put_ins(16'h0024, OP_LA, 8'h00, 16'h0012, 16'h3400);
      put_ins(16'h0029, OP_LPMR, 8'h00, 16'h5a00, 16'h0000);
      put_ins(16'h002e, OP_BR, 8'h04, 16'h0000, 16'h6000);
      put_ins(16'h0033, OP_BR, 8'h02, 16'h0000, 16'h6000);
      put_ins(16'h0038, OP_SVC, 8'h00, 16'hee00, 16'h0000);
      put_ins(16'h0060, OP_SVC, 8'h00, 16'ha500, 16'h0000);
      put_ins(16'h0400, OP_SVC, 8'h00, 16'h7700, 16'h0000);
      {i_mem.mem[LOAD_END - 16'h2], i_mem.mem[LOAD_END - 16'h1], i_mem.mem[LOAD_END]} = 24'h040008;
      repeat (7) @(posedge i_clk);
      @(negedge i_clk);
      chk("reset alt and strobes", 16'h001c, 16'({o_alt_mode, o_ras_n, o_cas_n, o_rw_sel, o_irq5_req}));
      chk("reset iar", 16'h0000, o_iar);
      @(posedge i_clk) i_srst <= 1'b0;
      i_more_instr <= 1'b1;
      hold_idle(20);
      chk("alt held", 16'h1, 16'(o_alt_mode));
      @(posedge i_clk) i_run_permit_n <= 1'b0;
      i_more_instr <= 1'b0;
      hold_idle(20);
      @(posedge i_clk) i_more_instr <= 1'b1;
      wait_for(1'b1, 5000);
      @(posedge i_clk) i_run_permit_n <= 1'b1;
      wait_for(1'b0, 300);
      for (int i = 0; i < 6; i++) begin
         chk("operand one", rows[i].ex, mw(16'h0301 + 16'(4 * i)));
      end
      chk("recall addr", 16'h0038, o_arr);
      chk("load address", 16'h1234, o_lsr_xr);
      chk("mode reg", 16'h005a, 16'(o_pmr));
      chk("recall slot", 16'h00a5, 16'(o_recall_slot));
      chk("saved recall", 16'h00a5, 16'(i_mem.mem[SAVE_END]));
      chk("saved iar", 16'h0065, mw(SAVE_END - 16'h2));
      @(posedge i_clk) i_status_byte2 <= 8'h40;
      i_run_permit_n <= 1'b0;
      wait_for(1'b1, 2000);
      @(posedge i_clk) i_run_permit_n <= 1'b1;
      wait_for(1'b0, 300);
      chk("loaded recall", 16'h0077, 16'(i_mem.mem[SAVE_END]));
      chk("loaded status", 16'h0008, 16'(i_mem.mem[SAVE_END - 16'h1]));
      chk("loaded iar", 16'h0405, mw(SAVE_END - 16'h2));
      chk("status reg", 16'h0008, 16'(o_psr));
      chk("stack acc", 16'h0000, 16'(o_lsr_acc));
      complete_run();
   end
endmodule : testbench
